// >>> common/adc_port_pkg.sv
package adc_port_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;

    // Convert pulse must last at least this long
    localparam int unsigned CONVERT_PULSE_NS = 40;
    localparam int unsigned CONVERT_PULSE_CYC =
        (CONVERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Busy-low period, longest
    localparam int unsigned CONV_MAX_NS = 2000;
    localparam int unsigned CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;

    // Result settles ahead of busy release
    localparam int unsigned DATA_LEAD_NS = 35;
    localparam int unsigned DATA_LEAD_CYC =
        (DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Previous result stays valid this long after a start
    localparam int unsigned HOLD_OLD_NS = 1500;
    localparam int unsigned HOLD_OLD_CYC =
        (HOLD_OLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CODE_POS_FS = 16'h7fff;
    localparam logic [15:0] CODE_NEG_FS = 16'h8000;

endpackage

// >>> common/sample_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link between the control port and the sampler
interface sample_if;
    logic hold;
    logic [15:0] sample;
    modport ctrl (output hold, input sample);
    modport sampler (input hold, output sample);
endinterface
`default_nettype wire

// >>> logic/sample_hold.sv
`timescale 1ns/1ps
`default_nettype none
module sample_hold (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [15:0] analog_code,
    sample_if.sampler sh
);
    logic [15:0] held;
    logic [15:0] next_held;

    // Track while not holding, freeze while converting
    always_comb begin
        next_held = sh.hold ? held : analog_code;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            held <= adc_port_pkg::RESULT_RESET;
        end else if (clk_en) begin
            held <= next_held;
        end
    end

    assign sh.sample = held;
endmodule
`default_nettype wire

// >>> logic/adc_conv_port.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conv_port #(
    parameter int unsigned CONV_CYCLES = adc_port_pkg::CONV_CYC,
    parameter int unsigned OLD_CYCLES = adc_port_pkg::HOLD_OLD_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic select_b,
    input wire logic read_conv,
    input wire logic byte_sel,
    input wire logic word_mode,
    input wire logic [15:0] analog_code,
    output logic busy_b,
    output logic [15:0] result_out,
    output logic [15:0] result_oe_b,
    output logic sampler_hold
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic sel_low;
    logic rc_low;
    logic bsel;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 3'h3;
            pin_sync <= 3'h3;
        end else if (clk_en) begin
            pin_meta <= {byte_sel, read_conv, select_b};
            pin_sync <= pin_meta;
        end
    end

    assign sel_low = !pin_sync[0];
    assign rc_low = !pin_sync[1];
    assign bsel = pin_sync[2];

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CONV = 3'h2,
        ST_DONE = 3'h4
    } conv_state_e;

    conv_state_e state;
    conv_state_e next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [15:0] result;
    logic [15:0] next_result;
    logic [15:0] old_cnt;
    logic [15:0] next_old_cnt;
    logic start_lvl;
    logic start_prev;
    logic next_start_prev;
    logic start;

    // the bus is registered behind the result
    // so the store comes one edge plus the data lead before busy rises
    localparam logic [15:0] STORE_AT =
        16'(CONV_CYCLES - 2 - adc_port_pkg::DATA_LEAD_CYC);

    sample_if sh ();

    sample_hold u_sh (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .analog_code(analog_code),
        .sh(sh)
    );

    assign start_lvl = sel_low && rc_low;
    // start on entry to joint low
    assign start = start_lvl && !start_prev && (state == ST_IDLE);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_result = result;
        next_start_prev = start_lvl;
        next_old_cnt = (old_cnt != 16'h0000) ? old_cnt - 16'h0001 : old_cnt;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_CONV;
                    next_cnt = 16'h0000;
                    next_old_cnt = OLD_CYCLES[15:0];
                end
            end
            ST_CONV: begin
                next_cnt = cnt + 16'h0001;
                // store early enough for the bus to settle
                if (cnt == STORE_AT) begin
                    next_result = sh.sample;
                end
                if (cnt == CONV_CYCLES[15:0] - 16'h0001) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            cnt <= 16'h0000;
            result <= adc_port_pkg::RESULT_RESET;
            old_cnt <= 16'h0000;
            start_prev <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
            result <= next_result;
            old_cnt <= next_old_cnt;
            start_prev <= next_start_prev;
        end
    end

    assign busy_b = (state != ST_CONV);
    assign sh.hold = (state == ST_CONV);
    assign sampler_hold = sh.hold;

    ////////////////////////////////////////////////////////////////////
    // Output bus
    logic drive;
    logic [15:0] next_out;
    logic [15:0] next_oe_b;
    logic [15:0] word;

    // drive only with convert high and select low
    // a start turns the bus off
    assign drive = sel_low && !rc_low;

    always_comb begin
        // twos complement, msb on top line
        word = result;
        next_out = word;
        next_oe_b = drive ? 16'h0000 : 16'hffff;
        if (!word_mode) begin
            next_out = {8'h00, bsel ? word[7:0] : word[15:8]};
            next_oe_b = drive ? 16'hff00 : 16'hffff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            result_out <= adc_port_pkg::RESULT_RESET;
            result_oe_b <= 16'hffff;
        end else if (clk_en) begin
            result_out <= next_out;
            result_oe_b <= next_oe_b;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    // Longest busy-low run, in clock cycles
    localparam int BUSY_MAX = int'(CONV_CYCLES);

    // old result kept while count runs
    a_old_result_kept: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && old_cnt != 16'h0000) |=> $stable(result))
        else $error("previous result changed too early");

    a_busy_bound: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        $fell(busy_b) |-> ##[1:BUSY_MAX] busy_b)
        else $error("busy held low too long");

    a_start_busy: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && start) |=> !busy_b)
        else $error("start did not lower busy");

    a_start_hold: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && start) |=> sampler_hold)
        else $error("start did not hold the sampler");

    a_sample_frozen: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && sampler_hold) |=> $stable(sh.sample))
        else $error("held sample moved during conversion");

    a_hold_tracks: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        busy_b |-> !sampler_hold)
        else $error("sampler held while not busy");

    // sampler follows the input when released
    a_sampler_follows: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && !sampler_hold) |=> sh.sample == $past(analog_code))
        else $error("sampler not tracking the input");

    // busy rise carries this conversion's sample
    a_busy_result: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && $rose(busy_b)) |-> result == sh.sample)
        else $error("result at busy rise is not the held sample");

    a_bus_off_sel: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && !sel_low) |=> result_oe_b == 16'hffff)
        else $error("bus driven with select high");

    a_idle_no_start: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && !sel_low && state == ST_IDLE) |=> busy_b)
        else $error("conversion started with select high");

    a_bus_on_read: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && drive && word_mode) |=> result_oe_b == 16'h0000)
        else $error("bus not driven in read");

    // convert low turns the bus off
    a_bus_off_conv: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && rc_low) |=> result_oe_b == 16'hffff)
        else $error("bus driven with convert low");

    // bus lags result by an edge, so result settles two early
    a_result_before: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && $rose(busy_b)) |->
            $stable(result) && $past(result) == $past(result, 2))
        else $error("result changed too close to busy rise");

    // word mode shows the stored result
    a_word_out: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && word_mode) |=> result_out == $past(result))
        else $error("word output differs from result");

    // select low gives the upper byte
    a_byte_lane: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && !word_mode && !bsel) |=>
            result_out[7:0] == $past(result[15:8]))
        else $error("wrong byte presented");

    // select high gives the lower byte
    a_low_byte: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && !word_mode && bsel) |=>
            result_out[7:0] == $past(result[7:0]))
        else $error("wrong lower byte presented");

    // byte mode drives the low lane only
    a_byte_oe: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (clk_en && drive && !word_mode) |=>
            result_oe_b == 16'hff00 && result_out[15:8] == 8'h00)
        else $error("byte mode lane wrong");
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    output logic select_b,
    output logic read_conv,
    output logic byte_sel
);
    initial begin
        select_b = 1'b1;
        read_conv = 1'b1;
        byte_sel = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // pin order
    // Pins move only after a falling edge, all at once
    task automatic pins(input logic s, input logic r, input logic b);
        @(negedge ref_clk);
        select_b = s;
        read_conv = r;
        byte_sel = b;
    endtask
endmodule
`default_nettype wire

// >>> testbench/sar_adc_parallel_conversion_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_conversion_port_tb;
    localparam int unsigned CONV = 12;
    localparam int unsigned OLD = 6;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic word_mode = 1'b1;
    logic [15:0] analog_code = 16'h0000;
    logic select_b, read_conv, byte_sel, busy_b, sampler_hold;
    logic [15:0] result_out, result_oe_b;
    logic [15:0] codes [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0000};
    int mismatches = 0;
    int total_checks = 0;
    int low_run = 0;
    int last_run = 0;
    logic [15:0] last_low_out = 16'h0000;
    always #25 ref_clk = ~ref_clk;
    host_model host_model_inst (.ref_clk(ref_clk), .select_b(select_b),
        .read_conv(read_conv), .byte_sel(byte_sel));
    adc_conv_port #(.CONV_CYCLES(CONV), .OLD_CYCLES(OLD)) adc_conv_port_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1),
        .select_b(select_b), .read_conv(read_conv), .byte_sel(byte_sel),
        .word_mode(word_mode), .analog_code(analog_code),
        .busy_b(busy_b), .result_out(result_out),
        .result_oe_b(result_oe_b), .sampler_hold(sampler_hold));
    ////////////////////////////////////////////////////////////////////
    // Length of the last busy-low run, in clock cycles
    always @(posedge ref_clk) begin
        if (busy_b === 1'b0) begin
            low_run <= low_run + 1;
        end else if (low_run != 0) begin
            last_run <= low_run;
            low_run <= 0;
        end
    end
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Bounded, so a stuck busy flag cannot hang the run
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy_b !== lvl && n < 100) begin
            last_low_out = result_out;
            @(negedge ref_clk);
            n++;
        end
        check("busy wait", 16'(n == 100), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] code;
        logic [15:0] prev;
        void'($urandom(7119));
        prev = adc_port_pkg::RESULT_RESET;
        idle(12);
        rst_b = 1'b1;
        check("oe after reset", result_oe_b, 16'hffff);
        check("busy after reset", 16'(busy_b), 16'h0001);
        // convert low with select high starts nothing
        host_model_inst.pins(1'b1, 1'b0, 1'b1);
        idle(6);
        check("no start", 16'(busy_b), 16'h0001);
        host_model_inst.pins(1'b1, 1'b1, 1'b0);
        idle(3);
        check("oe no select", result_oe_b, 16'hffff);
        for (int i = 0; i < 10; i++) begin
            code = (i < 4) ? codes[i] : 16'($urandom);
            analog_code = code;
            if (i[0]) begin
                host_model_inst.pins(1'b0, 1'b0, 1'b0);
            end else begin
                host_model_inst.pins(1'b1, 1'b0, 1'b0);
                host_model_inst.pins(1'b0, 1'b0, 1'b0);
            end
            wait_busy(1'b0);
            // Input moves once held; the result must not follow it
            analog_code = ~code;
            check("hold", 16'(sampler_hold), 16'h0001);
            check("oe at start", result_oe_b, 16'hffff);
            if (i[0]) begin
                // old word read early in the conversion
                host_model_inst.pins(1'b0, 1'b1, 1'b0);
                idle(3);
                check("old word", result_out, prev);
            end else begin
                host_model_inst.pins(1'b1, 1'b1, 1'b0);
                idle(3);
                check("oe select high", result_oe_b, 16'hffff);
            end
            wait_busy(1'b1);
            if (i[0]) begin
                check("lead word", last_low_out, code);
                check("word at rise", result_out, code);
            end
            idle(1);
            check("busy length", 16'(last_run), 16'(CONV));
            check("tracking", 16'(sampler_hold), 16'h0000);
            // new word taken after busy rises, as a word and as both bytes
            host_model_inst.pins(1'b0, 1'b1, 1'b0);
            idle(3);
            check("oe word", result_oe_b, 16'h0000);
            check("word", result_out, code);
            word_mode = 1'b0;
            idle(3);
            check("oe byte", result_oe_b, 16'hff00);
            check("upper byte", result_out, {8'h00, code[15:8]});
            host_model_inst.pins(1'b0, 1'b1, 1'b1);
            idle(3);
            check("lower byte", result_out, {8'h00, code[7:0]});
            word_mode = 1'b1;
            prev = code;
            idle(70);
        end
        give_verdict();
    end
    initial begin
        #(3000 * 50);
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
